// [src/eprom_entry_defines.svh]
// How it works
// - Program address pins 0-13 pick the byte, pins 15:14 pick one of four modules.
// - Font address pins 0-11 pick the byte, pin 12 picks low or high bank.
// - Glyph word is high bank low nibble over the full low bank byte.
// - Verify: write strobe high, output enable low, device drives addressed byte.
// - Pins reach the selected memory directly; other memory controls made inside.
// - Reset pin is serial data, crystal input is shift clock during entry.
// - Code is ten bits, first bit shifted is a zero start bit.
// - Code bits 5:1 select mode: 00100 program memory, 00110 font memory.
// - Code bits 9:6 are the end marker 0101, shifted last.
// - Reset held 24 crystal clocks; modes cancelled by 10th, core reset by 24th.
// - Controls become ready two crystal clocks after the last code bit.
// - Reset pin high for 10 consecutive crystal clocks leaves programming mode.
`ifndef EPROM_ENTRY_DEFINES_SVH
`define EPROM_ENTRY_DEFINES_SVH

// Serial code framing
`define CODE_BITS       10
`define CODE_START_POS  0
`define CODE_START_VAL  1'h0
`define CODE_MODE_LSB   1
`define CODE_MODE_MSB   5
`define CODE_STOP_LSB   6
`define CODE_STOP_MSB   9
`define CODE_STOP_VAL   4'h5
`define MODE_PROGRAM    5'h04
`define MODE_FONT       5'h06

// Timing in crystal clocks
`define XT_CANCEL       5'd10
`define XT_CORE_RESET   5'd24
`define XT_READY        2'd2
`define XT_EXIT         5'd10

// Register offsets and reset values
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define CTRL_RESET      32'h0000_0001
`define CTRL_ENTRY_BIT  0
`define STAT_PROG_BIT   0
`define STAT_FONT_BIT   1
`define STAT_CORE_BIT   2
`define STAT_ARMED_BIT  3

`endif

// [src/eprom_entry_pkg.sv]
package eprom_entry_pkg;

    // Entry sequence states
    typedef enum logic [1:0] {
        st_idle,
        st_armed,
        st_settle,
        st_prog
    } entry_state_t;

    // Programmer pins in programming mode
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
        logic        we_n;
        logic        oe_n;
    } prog_pins_t;

endpackage : eprom_entry_pkg

// [src/eprom_program_mode_entry.sv]
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "eprom_entry_defines.svh"

module eprom_program_mode_entry
    import eprom_entry_pkg::*;
#(
    parameter int PROG_AW = 16,
    parameter int FONT_AW = 12
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        crystal_input_clock,
    input  wire logic        reset_pin,
    input  wire prog_pins_t  prog_pins,
    output logic [7:0]       data_out,
    output logic             data_oe,
    output logic             core_reset,
    input  wire logic [15:0] cpu_addr,
    output logic [7:0]       cpu_data,
    input  wire logic [11:0] glyph_addr,
    output logic [11:0]      glyph_word,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);

    // Program space must split into four modules, font space into two banks
    if (PROG_AW != 16 || FONT_AW != 12) begin : g_width_check
        $error("Address widths are fixed by the pin map");
    end

    // ************************************************************
    // Crystal edge and reset pin history
    // ************************************************************
    logic                  xtal_prev;
    logic                  xtal_rise;
    logic [4:0]            high_cnt;
    logic [4:0]            next_high_cnt;
    logic [`CODE_BITS-1:0] code;
    logic [`CODE_BITS-1:0] next_code;

    // Bits taken on the crystal rising edge only
    assign xtal_rise = crystal_input_clock & ~xtal_prev;

    // Reset pin shifts in LSB first; consecutive-high count saturates
    always_comb begin
        next_code     = code;
        next_high_cnt = high_cnt;
        if (xtal_rise) begin
            next_code = {reset_pin, code[`CODE_BITS-1:1]};
            if (!reset_pin) begin
                next_high_cnt = 5'd0;
            end else if (high_cnt != `XT_CORE_RESET) begin
                next_high_cnt = high_cnt + 5'd1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            xtal_prev <= 1'b0;
            high_cnt  <= 5'd0;
            code      <= '1;
        end else begin
            xtal_prev <= crystal_input_clock;
            high_cnt  <= next_high_cnt;
            code      <= next_code;
        end
    end

    // ************************************************************
    // Code decode and mode sequence
    // ************************************************************
    logic [4:0]   mode_bits;
    logic         code_ok;
    logic         code_font;
    entry_state_t state;
    entry_state_t next_state;
    logic [1:0]   wait_cnt;
    logic [1:0]   next_wait_cnt;
    logic         font_mode;
    logic         next_font_mode;
    logic         entry_en;

    // Entry only on a fully framed code with a known mode
    assign mode_bits = next_code[`CODE_MODE_MSB:`CODE_MODE_LSB];
    assign code_font = (mode_bits == `MODE_FONT);
    assign code_ok   = (next_code[`CODE_START_POS] == `CODE_START_VAL)
                     & (next_code[`CODE_STOP_MSB:`CODE_STOP_LSB] == `CODE_STOP_VAL)
                     & ((mode_bits == `MODE_PROGRAM) | code_font);

    // Reset high long enough arms entry; a long high also drops any mode
    always_comb begin
        next_state     = state;
        next_wait_cnt  = wait_cnt;
        next_font_mode = font_mode;
        if (xtal_rise) begin
            unique case (state)
                st_idle: begin
                    if (next_high_cnt == `XT_CORE_RESET) begin
                        next_state = st_armed;
                    end
                end
                st_armed: begin
                    if (code_ok && entry_en) begin
                        next_state     = st_settle;
                        next_wait_cnt  = 2'd0;
                        next_font_mode = code_font;
                    end
                end
                st_settle: begin
                    next_wait_cnt = wait_cnt + 2'd1;
                    if (wait_cnt == `XT_READY - 2'd1) begin
                        next_state = st_prog;
                    end
                end
                st_prog: begin
                    next_state = st_prog;
                end
            endcase
            // Cancel before the 10th high clock is over
            if ((state == st_settle || state == st_prog) && next_high_cnt >= `XT_EXIT) begin
                next_state = st_idle;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state     <= st_idle;
            wait_cnt  <= 2'd0;
            font_mode <= 1'b0;
        end else begin
            state     <= next_state;
            wait_cnt  <= next_wait_cnt;
            font_mode <= next_font_mode;
        end
    end

    // ************************************************************
    // Memories and pin routing
    // ************************************************************
    logic [7:0] prog_mem [0:(1<<PROG_AW)-1];
    logic [7:0] glyph_low_bank [0:(1<<FONT_AW)-1];
    logic [7:0] glyph_high_bank [0:(1<<FONT_AW)-1];
    logic       we_prev;
    logic       in_prog;
    logic       wr_strobe;
    logic       rd_enable;
    logic [7:0] rd_byte;
    logic       next_data_oe;
    logic [7:0] next_data_out;
    logic       next_core_reset;

    assign in_prog = (state == st_prog);
    // Write on the falling write strobe with output enable high
    assign wr_strobe = in_prog & ~prog_pins.we_n & we_prev & prog_pins.oe_n;
    assign rd_enable = in_prog & prog_pins.we_n & ~prog_pins.oe_n;

    // Font mode looks only at pins 12:0, so pins 15:13 are don't-care
    always_comb begin
        if (!font_mode) begin
            rd_byte = prog_mem[prog_pins.addr];
        end else if (prog_pins.addr[12]) begin
            rd_byte = glyph_high_bank[prog_pins.addr[11:0]];
        end else begin
            rd_byte = glyph_low_bank[prog_pins.addr[11:0]];
        end
    end

    // Data pins driven only during verify; core held in reset meanwhile
    always_comb begin
        next_data_oe    = rd_enable;
        next_data_out   = rd_enable ? rd_byte : 8'h00;
        next_core_reset = (high_cnt == `XT_CORE_RESET) | (state != st_idle);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            we_prev    <= 1'b1;
            data_oe    <= 1'b0;
            data_out   <= 8'h00;
            core_reset <= 1'b1;
        end else begin
            we_prev    <= prog_pins.we_n;
            data_oe    <= next_data_oe;
            data_out   <= next_data_out;
            core_reset <= next_core_reset;
        end
    end

    // Memory writes; no reset on array contents
    always_ff @(posedge clk) begin
        if (wr_strobe && !font_mode) begin
            prog_mem[prog_pins.addr] <= prog_pins.data;
        end
        if (wr_strobe && font_mode && !prog_pins.addr[12]) begin
            glyph_low_bank[prog_pins.addr[11:0]] <= prog_pins.data;
        end
        if (wr_strobe && font_mode && prog_pins.addr[12]) begin
            glyph_high_bank[prog_pins.addr[11:0]] <= prog_pins.data;
        end
    end

    // CPU side reads; glyph word joins the two banks
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cpu_data   <= 8'h00;
            glyph_word <= 12'h000;
        end else begin
            cpu_data   <= prog_mem[cpu_addr];
            glyph_word <= {glyph_high_bank[glyph_addr][3:0], glyph_low_bank[glyph_addr]};
        end
    end

    // ************************************************************
    // APB register slave
    // ************************************************************
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [31:0] status;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        access;
    logic        mapped;

    // One wait state keeps pready and prdata straight from flops
    assign access   = psel & penable & ~pready;
    assign mapped   = (paddr == `OFS_CTRL) | (paddr == `OFS_STATUS);
    assign entry_en = ctrl[`CTRL_ENTRY_BIT];

    always_comb begin
        status                  = 32'h0000_0000;
        status[`STAT_PROG_BIT]  = in_prog;
        status[`STAT_FONT_BIT]  = font_mode;
        status[`STAT_CORE_BIT]  = core_reset;
        status[`STAT_ARMED_BIT] = (state == st_armed);
        next_ctrl    = ctrl;
        next_prdata  = 32'h0000_0000;
        next_pready  = access;
        next_pslverr = access & ~mapped;
        if (access && pwrite && paddr == `OFS_CTRL) begin
            next_ctrl = {31'h0000_0000, pwdata[`CTRL_ENTRY_BIT]};
        end
        if (access && !pwrite && paddr == `OFS_CTRL) begin
            next_prdata = ctrl;
        end
        if (access && !pwrite && paddr == `OFS_STATUS) begin
            next_prdata = status;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl    <= `CTRL_RESET;
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl    <= next_ctrl;
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_exit_on_high: assert property (@(posedge clk) disable iff (!rst_n)
        (state == st_prog && xtal_rise && reset_pin && high_cnt == `XT_EXIT - 5'd1)
        |=> state == st_idle)
        else $error("Programming mode kept after long reset high");

    a_cancel_modes: assert property (@(posedge clk) disable iff (!rst_n)
        (high_cnt >= `XT_CANCEL) |-> !(state inside {st_settle, st_prog}))
        else $error("Special mode still active after ten high clocks");

    a_core_reset: assert property (@(posedge clk) disable iff (!rst_n)
        (high_cnt == `XT_CORE_RESET) |=> core_reset)
        else $error("Core not reset after 24 high clocks");

    a_entry_frame: assert property (@(posedge clk) disable iff (!rst_n)
        (state == st_armed) ##1 (state == st_settle)
        |-> $past(code_ok) && code[`CODE_STOP_MSB:`CODE_STOP_LSB] == `CODE_STOP_VAL)
        else $error("Entry without a framed code");

    a_ready_wait: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(state == st_prog) |-> $past(wait_cnt) == `XT_READY - 2'd1)
        else $error("Controls ready too early or late");

    a_verify_drive: assert property (@(posedge clk) disable iff (!rst_n)
        rd_enable |=> data_oe && data_out == $past(rd_byte))
        else $error("Verify did not drive the addressed byte");

    a_no_drive_pgm: assert property (@(posedge clk) disable iff (!rst_n)
        (prog_pins.oe_n || !in_prog) |=> !data_oe)
        else $error("Data pins driven outside verify");

    a_write_gated: assert property (@(posedge clk) disable iff (!rst_n)
        wr_strobe |-> state == st_prog && prog_pins.oe_n)
        else $error("Memory written outside programming mode");

    a_apb_answer: assert property (@(posedge clk) disable iff (!rst_n)
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("APB answer not one wait state");

endmodule : eprom_program_mode_entry

`default_nettype wire

// [tb/eprom_programmer_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// External programmer at the package pins
// ****************************************
module eprom_programmer_model
    import eprom_entry_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    output logic            crystal_input_clock,
    output logic            reset_pin,
    output prog_pins_t      prog_pins
);
    logic [15:0] addr;
    logic [7:0]  drv;
    logic        we_n;
    logic        oe_n;

    // Shared data wire: device wins while it drives
    assign prog_pins = {addr, (data_oe ? data_out : drv), we_n, oe_n};

    // Pins idle, strobes inactive
    initial begin
        crystal_input_clock = 1'b0;
        reset_pin = 1'b0;
        addr = 16'h0000;
        drv = 8'h00;
        we_n = 1'b1;
        oe_n = 1'b1;
    end

    // One crystal period, each level two system clocks
    task automatic xt(input logic b);
        @(posedge clk) crystal_input_clock <= 1'b0;
        reset_pin <= b;
        @(posedge clk);
        @(posedge clk) crystal_input_clock <= 1'b1;
        @(posedge clk);
    endtask : xt

    // Ordinary reset first, then the code with bit 0 first
    task automatic enter(input logic [9:0] code, input int n_hi);
        for (int i = 0; i < n_hi; i++) xt(1'b1);
        for (int i = 0; i < 10; i++) xt(code[i]);
    endtask : enter

    // Byte write; data driven to its complement afterwards so no stale value lingers
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk) addr <= a;
        drv <= d;
        @(posedge clk) we_n <= 1'b0;
        @(posedge clk) we_n <= 1'b1;
        @(posedge clk) drv <= ~d;
    endtask : wr

    // Verify cycle: output enable low, write strobe held high
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic oe);
        @(posedge clk) addr <= a;
        oe_n <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        #1 d = data_out;
        oe = data_oe;
        @(posedge clk) oe_n <= 1'b1;
    endtask : rd
endmodule : eprom_programmer_model
`default_nettype wire

// [tb/eprom_program_mode_entry_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "eprom_entry_defines.svh"
// ****************************************
// Bench top
// ****************************************
module eprom_program_mode_entry_tb_top
    import eprom_entry_pkg::*;
;
    logic        clk, rst_n, xtal, rpin, data_oe, core_reset;
    prog_pins_t  pins;
    logic [7:0]  data_out, cpu_data, paddr, d;
    logic [15:0] cpu_addr;
    logic [11:0] glyph_addr, glyph_word;
    logic        psel, penable, pwrite, pready, pslverr, e, oe;
    logic [31:0] pwdata, prdata, v;
    int          n_mismatch = 0;
    int          tests_run = 0;
    logic [15:0] row_addr [4] = '{16'h1234, 16'h5234, 16'h9234, 16'hD234};
    logic [7:0]  row_data [4] = '{8'h11, 8'h22, 8'h44, 8'h88};

    eprom_program_mode_entry i_dut (.clk(clk), .rst_n(rst_n), .crystal_input_clock(xtal),
        .reset_pin(rpin), .prog_pins(pins), .data_out(data_out), .data_oe(data_oe),
        .core_reset(core_reset), .cpu_addr(cpu_addr), .cpu_data(cpu_data),
        .glyph_addr(glyph_addr), .glyph_word(glyph_word), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    eprom_programmer_model i_prog (.clk(clk), .data_out(data_out), .data_oe(data_oe),
        .crystal_input_clock(xtal), .reset_pin(rpin), .prog_pins(pins));

    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic conclude();
        if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // APB transfer; the wait on pready is bounded so a hang ends the run
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk) psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk) penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Main sequence
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite} = 3'b000;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        cpu_addr = 16'h0000;
        glyph_addr = 12'h000;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("core_reset", 32'(core_reset), 32'h0000_0000);
        apb(1'b0, `OFS_CTRL, 32'h0000_0000, v, e);
        chk("ctrl", v, 32'h0000_0001);
        apb(1'b1, `OFS_CTRL, 32'h0000_0000, v, e);
        apb(1'b0, `OFS_CTRL, 32'h0000_0000, v, e);
        chk("ctrl", v, 32'h0000_0000);
        apb(1'b1, `OFS_CTRL, 32'h0000_0001, v, e);
        apb(1'b0, 8'h10, 32'h0000_0000, v, e);
        chk("unmapped err", 32'(e), 32'h0000_0001);
        i_prog.rd(16'h1234, d, oe);
        chk("oe idle", 32'(oe), 32'h0000_0000);
        // Bad end marker must be ignored while armed
        i_prog.enter({4'b0111, 5'b00100, 1'b0}, 24);
        i_prog.xt(1'b0);
        i_prog.xt(1'b0);
        chk("core_reset", 32'(core_reset), 32'h0000_0001);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000, v, e);
        chk("status", v & 32'h0000_0009, 32'h0000_0008);
        // Start bit of one must be ignored too
        i_prog.enter({4'b0101, 5'b00100, 1'b1}, 0);
        i_prog.xt(1'b0);
        i_prog.xt(1'b0);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000, v, e);
        chk("status", v & 32'h0000_0009, 32'h0000_0008);
        i_prog.enter({4'b0101, 5'b00100, 1'b0}, 0);
        i_prog.xt(1'b0);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000, v, e);
        chk("status", v & 32'h0000_0001, 32'h0000_0000);
        i_prog.xt(1'b0);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000, v, e);
        chk("status", v & 32'h0000_0001, 32'h0000_0001);
        // Same offset in all four modules: aliasing shows up
        for (int i = 0; i < 4; i++) i_prog.wr(row_addr[i], row_data[i]);
        for (int i = 0; i < 4; i++) begin
            i_prog.rd(row_addr[i], d, oe);
            chk("verify", 32'(d), 32'(row_data[i]));
            chk("oe", 32'(oe), 32'h0000_0001);
            @(posedge clk) cpu_addr <= row_addr[i];
            @(posedge clk);
            #1 chk("cpu_data", 32'(cpu_data), 32'(row_data[i]));
        end
        // Exit needs ten consecutive high crystal clocks
        repeat (9) i_prog.xt(1'b1);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000, v, e);
        chk("status", v & 32'h0000_0001, 32'h0000_0001);
        i_prog.xt(1'b1);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000, v, e);
        chk("status", v & 32'h0000_0001, 32'h0000_0000);
        i_prog.rd(16'h1234, d, oe);
        chk("oe exit", 32'(oe), 32'h0000_0000);
        // Font mode: top address pins are junk and must be ignored
        i_prog.enter({4'b0101, 5'b00110, 1'b0}, 24);
        i_prog.xt(1'b0);
        i_prog.xt(1'b0);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000, v, e);
        chk("status", v & 32'h0000_0002, 32'h0000_0002);
        i_prog.wr(16'hE123, 8'h5C);
        i_prog.wr(16'h1123, 8'hFA);
        @(posedge clk) glyph_addr <= 12'h123;
        @(posedge clk);
        #1 chk("glyph_word", 32'(glyph_word), 32'h0000_0A5C);
        i_prog.rd(16'h0123, d, oe);
        chk("font verify", 32'(d), 32'h0000_005C);
        conclude();
    end
endmodule : eprom_program_mode_entry_tb_top
`default_nettype wire
